// *** rtc_ctrl_consts.vh ***
// Register map, field layout, reset values and timing counts of the block
`ifndef RTC_CTRL_CONSTS_VH
`define RTC_CTRL_CONSTS_VH

// Byte addresses on the APB bus
`define ADDR_CLK_SRC_PS      8'h00
`define ADDR_PROT_FRZ_CAL    8'h04
`define ADDR_IRQ_EN          8'h08
`define ADDR_EVENT_FLAGS     8'h0c
`define ADDR_CTRL_STATUS     8'h10

// clock_source_prescale_ctrl fields
`define SRC_SEL_HI           7
`define SRC_SEL_LO           6
`define PRESCALE_HI          3
`define PRESCALE_LO          0
`define CLK_SRC_PS_RST       8'h00
`define CLK_SRC_PS_MASK      8'hcf

// Source select codes
`define SRC_MAIN_OSC         2'h0
`define SRC_WATCH_XTAL       2'h1
`define SRC_INT_1MHZ         2'h2

// protect_freeze_cal_ctrl fields
`define KEY_HI               7
`define KEY_LO               6
`define HALT_DBG_BIT         3
`define CAL_SEL_BIT          1
`define PROT_FRZ_CAL_RST     8'h00
`define PROT_FRZ_CAL_MASK    8'h0a

// Key values of the lock and unlock sequences
`define KEY_LOCK             2'h2
`define KEY_UNLOCK_1         2'h0
`define KEY_UNLOCK_2         2'h1
`define KEY_UNLOCK_3         2'h3
`define KEY_UNLOCK_4         2'h2

// interrupt_enable_ctrl and event_flag_status bit positions
`define HOUR_BIT             5
`define MINUTE_BIT           4
`define SECOND_BIT           3
`define COMP_BIT             2
`define TICK_BIT             0
`define IRQ_EN_RST           8'h00
`define IRQ_EN_MASK          8'h3d
`define EVENT_FLAGS_RST      8'h00

// Control status bit positions
`define STAT_PROT_BIT        0
`define STAT_CLK_DONE_BIT    1

// Divider from the 1 MHz prescaled clock to the counter clock
`define COUNTER_DIV          6'd32
`define COUNTER_DIV_LAST     5'd31

`endif

// *** rise_detect.v ***
// Registered rising-edge detector for a group of sampled clock levels
`timescale 1ns/100ps
module rise_detect #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         arst_n_i,
  input  wire [W-1:0] level_i,
  output wire [W-1:0] level_q_o,
  output wire [W-1:0] rise_o
);

  reg [W-1:0] level_r;
  reg [W-1:0] prev_r;

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      level_r <= {W{1'b0}};
      prev_r  <= {W{1'b0}};
    end
    else
    begin
      level_r <= level_i;
      prev_r  <= level_r;
    end
  end

  assign level_q_o = level_r;
  assign rise_o    = level_r & ~prev_r;

endmodule

// *** rtc_clock_protect_irq_control.v ***
// Clock source, prescaler, write protection and interrupt gating of the RTC
`timescale 1ns/100ps
`include "rtc_ctrl_consts.vh"

module rtc_clock_protect_irq_control (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire        por_arst_n_i,
  input  wire        special_mode_i,
  input  wire        debug_freeze_i,
  input  wire        main_osc_clock_i,
  input  wire        watch_crystal_clock_i,
  input  wire        internal_1mhz_clock_i,
  input  wire        comp_1hz_clock_i,
  input  wire        hour_inc_i,
  input  wire        minute_inc_i,
  input  wire        second_inc_i,
  input  wire        comp_cycle_i,
  input  wire        quarter_tick_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  output wire        counter_tick_o,
  output wire        counter_source_clock_o,
  output wire        calibration_clock_out_o,
  output wire        write_protect_active_o,
  output wire        hour_irq_o,
  output wire        minute_irq_o,
  output wire        second_irq_o,
  output wire        comp_cycle_irq_o,
  output wire        quarter_sec_tick_irq_o
);

  // One-hot states of the key sequence tracker
  localparam [5:0] ST_OPEN   = 6'h01;
  localparam [5:0] ST_LOCK1  = 6'h02;
  localparam [5:0] ST_LOCKED = 6'h04;
  localparam [5:0] ST_UNL1   = 6'h08;
  localparam [5:0] ST_UNL2   = 6'h10;
  localparam [5:0] ST_UNL3   = 6'h20;

  // Normal-reset registers also clear on power-on reset
  wire        any_rst_n;
  wire        setup_ph;
  wire        access_ph;
  wire        wr_en;
  wire        wr_clk;
  wire        wr_prot;
  wire        wr_ie;
  wire        wr_flags;
  wire        addr_hit;
  wire [7:0]  wbyte;
  wire [1:0]  key_wr;
  wire [2:0]  clk_q;
  wire [2:0]  clk_rise;
  wire [1:0]  src_sel;
  wire [3:0]  prescale;
  wire [4:0]  ps_plus1;
  wire [3:0]  half_cnt;
  wire        frozen;
  wire [4:0]  flag_set;
  wire [4:0]  flag_clr;
  wire [4:0]  ie_bits;

  reg  [7:0]  clk_ctrl_r;
  reg         clk_written_r;
  reg         halt_dbg_r;
  reg         cal_sel_r;
  reg  [7:0]  ie_r;
  reg  [4:0]  flag_r;
  reg  [4:0]  flag_nxt;
  reg  [5:0]  prot_st_r;
  reg  [5:0]  prot_st_nxt;
  reg  [31:0] prdata_r;
  reg         pslverr_r;
  reg  [7:0]  rd_byte;
  reg  [3:0]  pre_cnt_r;
  reg  [3:0]  pre_cnt_nxt;
  reg         pre_tick;
  reg         div_clk_r;
  reg         src_tick;
  reg  [4:0]  div32_cnt_r;
  reg         cnt_tick_r;
  reg         src_level;
  reg         src_level_r;
  reg         cal_out_r;

  assign any_rst_n = arst_n_i & por_arst_n_i;

  // APB decode; zero wait states, read data captured in the setup phase
  assign setup_ph  = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign wr_en     = access_ph & pwrite_i & pstrb_i[0];
  assign wbyte     = pwdata_i[7:0];
  assign addr_hit  = (paddr_i == `ADDR_CLK_SRC_PS)   ||
                     (paddr_i == `ADDR_PROT_FRZ_CAL) ||
                     (paddr_i == `ADDR_IRQ_EN)       ||
                     (paddr_i == `ADDR_EVENT_FLAGS)  ||
                     (paddr_i == `ADDR_CTRL_STATUS);
  assign wr_clk    = wr_en & (paddr_i == `ADDR_CLK_SRC_PS);
  assign wr_prot   = wr_en & (paddr_i == `ADDR_PROT_FRZ_CAL);
  assign wr_ie     = wr_en & (paddr_i == `ADDR_IRQ_EN);
  assign wr_flags  = wr_en & (paddr_i == `ADDR_EVENT_FLAGS);
  assign key_wr    = wbyte[`KEY_HI:`KEY_LO];

  // Clock register: POR only, write-once outside special mode
  always @(posedge clk_i or negedge por_arst_n_i)
  begin
    if (!por_arst_n_i)
    begin
      clk_ctrl_r <= `CLK_SRC_PS_RST;
    end
    else if (wr_clk && (special_mode_i || !clk_written_r))
    begin
      clk_ctrl_r <= wbyte & `CLK_SRC_PS_MASK;
    end
  end

  // The write-once latch follows any reset so a normal reset reopens it
  always @(posedge clk_i or negedge any_rst_n)
  begin
    if (!any_rst_n)
    begin
      clk_written_r <= 1'b0;
    end
    else if (wr_clk)
    begin
      clk_written_r <= 1'b1;
    end
  end

  // Freeze and calibration select bits; key bits are not stored
  always @(posedge clk_i or negedge any_rst_n)
  begin
    if (!any_rst_n)
    begin
      halt_dbg_r <= 1'b0;
      cal_sel_r  <= 1'b0;
    end
    else if (wr_prot)
    begin
      halt_dbg_r <= wbyte[`HALT_DBG_BIT];
      cal_sel_r  <= wbyte[`CAL_SEL_BIT];
    end
  end

  // Key sequence tracker; a wrong step falls back, 00 restarts unlocking
  always @*
  begin
    prot_st_nxt = prot_st_r;
    if (wr_prot)
    begin
      case (prot_st_r)
        ST_OPEN:
          if (key_wr == `KEY_LOCK)
            prot_st_nxt = ST_LOCK1;
        ST_LOCK1:
          if (key_wr == `KEY_LOCK)
            prot_st_nxt = ST_LOCKED;
          else
            prot_st_nxt = ST_OPEN;
        ST_LOCKED:
          if (key_wr == `KEY_UNLOCK_1)
            prot_st_nxt = ST_UNL1;
        ST_UNL1:
          if (key_wr == `KEY_UNLOCK_2)
            prot_st_nxt = ST_UNL2;
          else if (key_wr != `KEY_UNLOCK_1)
            prot_st_nxt = ST_LOCKED;
        ST_UNL2:
          if (key_wr == `KEY_UNLOCK_3)
            prot_st_nxt = ST_UNL3;
          else if (key_wr == `KEY_UNLOCK_1)
            prot_st_nxt = ST_UNL1;
          else
            prot_st_nxt = ST_LOCKED;
        ST_UNL3:
          if (key_wr == `KEY_UNLOCK_4)
            prot_st_nxt = ST_OPEN;
          else if (key_wr == `KEY_UNLOCK_1)
            prot_st_nxt = ST_UNL1;
          else
            prot_st_nxt = ST_LOCKED;
        default:
          prot_st_nxt = ST_OPEN;
      endcase
    end
  end

  always @(posedge clk_i or negedge any_rst_n)
  begin
    if (!any_rst_n)
    begin
      prot_st_r <= ST_OPEN;
    end
    else
    begin
      prot_st_r <= prot_st_nxt;
    end
  end

  // Protection holds through the whole unlock walk until its last step
  assign write_protect_active_o = ~(prot_st_r[0] | prot_st_r[1]);

  // Interrupt enables
  always @(posedge clk_i or negedge any_rst_n)
  begin
    if (!any_rst_n)
    begin
      ie_r <= `IRQ_EN_RST;
    end
    else if (wr_ie)
    begin
      ie_r <= wbyte & `IRQ_EN_MASK;
    end
  end

  // Event flags {hour, minute, second, comp, tick}; a set beats a clear
  assign flag_set = {hour_inc_i, minute_inc_i, second_inc_i,
                     comp_cycle_i, quarter_tick_i};
  assign flag_clr = wr_flags ? {wbyte[`HOUR_BIT], wbyte[`MINUTE_BIT],
                                wbyte[`SECOND_BIT], wbyte[`COMP_BIT],
                                wbyte[`TICK_BIT]} : 5'h00;

  always @*
  begin
    flag_nxt = flag_set | (flag_r & ~flag_clr);
  end

  always @(posedge clk_i or negedge any_rst_n)
  begin
    if (!any_rst_n)
    begin
      flag_r <= 5'h00;
    end
    else
    begin
      flag_r <= flag_nxt;
    end
  end

  assign ie_bits = {ie_r[`HOUR_BIT], ie_r[`MINUTE_BIT], ie_r[`SECOND_BIT],
                    ie_r[`COMP_BIT], ie_r[`TICK_BIT]};

  assign hour_irq_o             = flag_r[4] & ie_bits[4];
  assign minute_irq_o           = flag_r[3] & ie_bits[3];
  assign second_irq_o           = flag_r[2] & ie_bits[2];
  assign comp_cycle_irq_o       = flag_r[1] & ie_bits[1];
  assign quarter_sec_tick_irq_o = flag_r[0] & ie_bits[0];

  // Read mux; the key field always reads zero
  always @*
  begin
    rd_byte = 8'h00;
    if (paddr_i == `ADDR_CLK_SRC_PS)
      rd_byte = clk_ctrl_r;
    else if (paddr_i == `ADDR_PROT_FRZ_CAL)
    begin
      rd_byte[`HALT_DBG_BIT] = halt_dbg_r;
      rd_byte[`CAL_SEL_BIT]  = cal_sel_r;
    end
    else if (paddr_i == `ADDR_IRQ_EN)
      rd_byte = ie_r;
    else if (paddr_i == `ADDR_EVENT_FLAGS)
    begin
      rd_byte[`HOUR_BIT]   = flag_r[4];
      rd_byte[`MINUTE_BIT] = flag_r[3];
      rd_byte[`SECOND_BIT] = flag_r[2];
      rd_byte[`COMP_BIT]   = flag_r[1];
      rd_byte[`TICK_BIT]   = flag_r[0];
    end
    else if (paddr_i == `ADDR_CTRL_STATUS)
    begin
      rd_byte[`STAT_PROT_BIT]     = write_protect_active_o;
      rd_byte[`STAT_CLK_DONE_BIT] = clk_written_r;
    end
  end

  always @(posedge clk_i or negedge any_rst_n)
  begin
    if (!any_rst_n)
    begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_r  <= {24'h000000, rd_byte};
      pslverr_r <= ~addr_hit;
    end
  end

  assign prdata_o  = prdata_r;
  assign pslverr_o = pslverr_r;
  assign pready_o  = 1'b1;

  // Sampled source clock levels and their rising edges
  rise_detect #(
    .W (3)
  ) u_clk_edges (
    .clk_i     (clk_i),
    .arst_n_i  (any_rst_n),
    .level_i   ({internal_1mhz_clock_i, watch_crystal_clock_i,
                 main_osc_clock_i}),
    .level_q_o (clk_q),
    .rise_o    (clk_rise)
  );

  assign src_sel  = clk_ctrl_r[`SRC_SEL_HI:`SRC_SEL_LO];
  assign prescale = clk_ctrl_r[`PRESCALE_HI:`PRESCALE_LO];
  assign ps_plus1 = {1'b0, prescale} + 5'h01;
  assign half_cnt = ps_plus1[4:1];

  // Main oscillator prescaler: one tick per prescale+1 oscillator rising edges
  always @*
  begin
    pre_cnt_nxt = pre_cnt_r;
    pre_tick    = 1'b0;
    if (clk_rise[0])
    begin
      if (pre_cnt_r >= prescale)
      begin
        pre_cnt_nxt = 4'h0;
        pre_tick    = 1'b1;
      end
      else
      begin
        pre_cnt_nxt = pre_cnt_r + 4'h1;
      end
    end
  end

  always @(posedge clk_i or negedge any_rst_n)
  begin
    if (!any_rst_n)
    begin
      pre_cnt_r <= 4'h0;
      div_clk_r <= 1'b0;
    end
    else if (clk_rise[0])
    begin
      pre_cnt_r <= pre_cnt_nxt;
      div_clk_r <= (pre_cnt_nxt < half_cnt);
    end
  end

  // Tick and level of the selected counter source; code 11 gives neither
  always @*
  begin
    src_tick  = 1'b0;
    src_level = 1'b0;
    case (src_sel)
      `SRC_MAIN_OSC:
      begin
        src_tick  = pre_tick;
        src_level = (prescale == 4'h0) ? clk_q[0] : div_clk_r;
      end
      `SRC_WATCH_XTAL:
      begin
        src_tick  = clk_rise[1];
        src_level = clk_q[1];
      end
      `SRC_INT_1MHZ:
      begin
        src_tick  = clk_rise[2];
        src_level = clk_q[2];
      end
      default:
      begin
        src_tick  = 1'b0;
        src_level = 1'b0;
      end
    endcase
  end

  // Halt only while debug freeze is active and the halt bit is set
  assign frozen = debug_freeze_i & halt_dbg_r;

  // 1 MHz sources divided by 32; the watch crystal drives the counter direct
  always @(posedge clk_i or negedge any_rst_n)
  begin
    if (!any_rst_n)
    begin
      div32_cnt_r <= 5'h00;
      cnt_tick_r  <= 1'b0;
    end
    else
    begin
      cnt_tick_r <= 1'b0;
      if (src_tick && !frozen)
      begin
        if (src_sel == `SRC_WATCH_XTAL)
        begin
          cnt_tick_r <= 1'b1;
        end
        else if (div32_cnt_r == `COUNTER_DIV_LAST)
        begin
          div32_cnt_r <= 5'h00;
          cnt_tick_r  <= 1'b1;
        end
        else
        begin
          div32_cnt_r <= div32_cnt_r + 5'h01;
        end
      end
    end
  end

  assign counter_tick_o = cnt_tick_r;

  // Clock outputs are registered, so they lag the sampled inputs by a cycle
  always @(posedge clk_i or negedge any_rst_n)
  begin
    if (!any_rst_n)
    begin
      src_level_r <= 1'b0;
      cal_out_r   <= 1'b0;
    end
    else
    begin
      src_level_r <= src_level;
      cal_out_r   <= cal_sel_r ? comp_1hz_clock_i : src_level;
    end
  end

  assign counter_source_clock_o  = src_level_r;
  assign calibration_clock_out_o = cal_out_r;

endmodule

// *** rtc_ctrl_checker.sv ***
// Port-level assertions for the RTC clock, protection and interrupt block
`timescale 1ns/100ps
`include "rtc_ctrl_consts.vh"
module rtc_ctrl_checker (
  input wire        clk_i,
  input wire        arst_n_i,
  input wire        por_arst_n_i,
  input wire        hour_inc_i,
  input wire        minute_inc_i,
  input wire        second_inc_i,
  input wire        comp_cycle_i,
  input wire        quarter_tick_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [7:0]  paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0]  pstrb_i,
  input wire [31:0] prdata_o,
  input wire        counter_tick_o,
  input wire        write_protect_active_o,
  input wire        hour_irq_o,
  input wire        minute_irq_o,
  input wire        second_irq_o,
  input wire        comp_cycle_irq_o,
  input wire        quarter_sec_tick_irq_o
);
  wire rst_n  = arst_n_i & por_arst_n_i;
  wire wr     = psel_i & penable_i & pwrite_i & pstrb_i[0];
  wire wr_en  = wr & (paddr_i == `ADDR_IRQ_EN);
  wire wr_key = wr & (paddr_i == `ADDR_PROT_FRZ_CAL) &
                (pwdata_i[7:6] == `KEY_LOCK);
  wire rd_key = psel_i & ~penable_i & ~pwrite_i &
                (paddr_i == `ADDR_PROT_FRZ_CAL);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  property p_wp_reset; $rose(rst_n) |-> !write_protect_active_o; endproperty
  a_wp_reset: assert property (p_wp_reset) else $error("protect set");
  // Both lock and unlock end on a 10 key write
  property p_wp_lock;
    $rose(write_protect_active_o) |-> $past(wr_key);
  endproperty
  a_wp_lock: assert property (p_wp_lock) else $error("lock no key");
  property p_wp_unlock;
    $fell(write_protect_active_o) |-> $past(wr_key);
  endproperty
  a_wp_unlock: assert property (p_wp_unlock) else $error("bad unlock");
  property p_key_read; rd_key |=> prdata_o[7:6] == 2'h0; endproperty
  a_key_read: assert property (p_key_read) else $error("key bits read");
  property p_tick; counter_tick_o |=> !counter_tick_o; endproperty
  a_tick: assert property (p_tick) else $error("tick too long");
  property p_hour; $rose(hour_irq_o) |-> $past(hour_inc_i) || $past(wr_en);
  endproperty
  a_hour: assert property (p_hour) else $error("hour request");
  property p_min; $rose(minute_irq_o) |-> $past(minute_inc_i) || $past(wr_en);
  endproperty
  a_min: assert property (p_min) else $error("minute request");
  property p_sec; $rose(second_irq_o) |-> $past(second_inc_i) || $past(wr_en);
  endproperty
  a_sec: assert property (p_sec) else $error("second request");
  property p_comp; $rose(comp_cycle_irq_o) |-> $past(comp_cycle_i) ||
    $past(wr_en); endproperty
  a_comp: assert property (p_comp) else $error("comp request");
  property p_qtr; $rose(quarter_sec_tick_irq_o) |-> $past(quarter_tick_i) ||
    $past(wr_en); endproperty
  a_qtr: assert property (p_qtr) else $error("tick request");
  property p_clr; $fell(hour_irq_o) |-> $past(wr); endproperty
  a_clr: assert property (p_clr) else $error("hour request lost");
  c_lock: cover property ($rose(write_protect_active_o));
  c_irq: cover property ($rose(hour_irq_o));
  c_tick: cover property (counter_tick_o);
endmodule

bind rtc_clock_protect_irq_control rtc_ctrl_checker u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .por_arst_n_i(por_arst_n_i),
  .hour_inc_i(hour_inc_i), .minute_inc_i(minute_inc_i),
  .second_inc_i(second_inc_i), .comp_cycle_i(comp_cycle_i),
  .quarter_tick_i(quarter_tick_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i), .prdata_o(prdata_o), .counter_tick_o(counter_tick_o),
  .write_protect_active_o(write_protect_active_o), .hour_irq_o(hour_irq_o),
  .minute_irq_o(minute_irq_o), .second_irq_o(second_irq_o),
  .comp_cycle_irq_o(comp_cycle_irq_o),
  .quarter_sec_tick_irq_o(quarter_sec_tick_irq_o));

// *** testbench.sv ***
// Self-checking bench for the RTC clock, protection and interrupt block
`timescale 1ns/100ps
`include "rtc_ctrl_consts.vh"
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
  fails = fails + 1; $display("unexpected at %0t: got %h expected %h", \
  $time, g, e); end end
module testbench;
  reg         clk_i = 1'b0;
  reg         arst_n_i = 1'b0;
  reg         por_arst_n_i = 1'b0;
  reg         special_mode_i = 1'b0;
  reg         freeze = 1'b0;
  reg  [2:0]  osc = 3'h0;
  reg         comp_1hz = 1'b0;
  reg  [5:0]  set_b = 6'h00;
  reg         psel_i = 1'b0;
  reg         penable_i = 1'b0;
  reg         pwrite_i = 1'b0;
  reg  [7:0]  paddr_i = 8'h00;
  reg  [31:0] pwdata_i = 32'h0;
  reg  [23:0] kseq = 24'ha187a2;
  reg  [11:0] ulk = 12'ha1e;
  reg  [31:0] rd;
  reg         err;
  wire [31:0] prdata_o;
  wire        pready_o, pslverr_o, tick, src_clk, cal_out, wp;
  wire [5:0]  irq;
  integer     fails = 0, n_tests = 0, cyc = 0, seed = 32'haafa;
  integer     i, t, p, ps, m_clk = 0, m_pfc = 0, m_ien = 0;
  integer     m_flg = 0, m_st = 0, m_wr1 = 0;

  assign irq[1] = 1'b0;
  rtc_clock_protect_irq_control uut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .por_arst_n_i(por_arst_n_i),
    .special_mode_i(special_mode_i), .debug_freeze_i(freeze),
    .main_osc_clock_i(osc[0]), .watch_crystal_clock_i(osc[1]),
    .internal_1mhz_clock_i(osc[2]), .comp_1hz_clock_i(comp_1hz),
    .hour_inc_i(set_b[5]), .minute_inc_i(set_b[4]), .second_inc_i(set_b[3]),
    .comp_cycle_i(set_b[2]), .quarter_tick_i(set_b[0]), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(4'h1), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .counter_tick_o(tick),
    .counter_source_clock_o(src_clk), .calibration_clock_out_o(cal_out),
    .write_protect_active_o(wp), .hour_irq_o(irq[5]), .minute_irq_o(irq[4]),
    .second_irq_o(irq[3]), .comp_cycle_irq_o(irq[2]),
    .quarter_sec_tick_irq_o(irq[0]));

  initial forever #5 clk_i = ~clk_i;
  // Sources kept fast so each divider path is seen in a short run
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc % 5 == 0) osc[0] <= ~osc[0];
    if (cyc % 20 == 0) osc[1] <= ~osc[1];
    if (cyc % 50 == 0) osc[2] <= ~osc[2];
    if (cyc == 60000)
    begin
      fails = fails + 1;
      finish_test;
    end
  end

  function integer nxt_st(input integer s, input [1:0] k);
  begin
    case (s)
      0: nxt_st = (k == `KEY_LOCK) ? 1 : 0;
      1: nxt_st = (k == `KEY_LOCK) ? 2 : 0;
      2: nxt_st = (k == `KEY_UNLOCK_1) ? 3 : 2;
      3: nxt_st = (k == `KEY_UNLOCK_2) ? 4 : (k == 2'h0) ? 3 : 2;
      4: nxt_st = (k == `KEY_UNLOCK_3) ? 5 : (k == 2'h0) ? 3 : 2;
      default: nxt_st = (k == `KEY_UNLOCK_4) ? 0 : (k == 2'h0) ? 3 : 2;
    endcase
  end
  endfunction

  function integer exp_rd(input [7:0] a);
  begin
    case (a)
      `ADDR_CLK_SRC_PS:   exp_rd = m_clk;
      `ADDR_PROT_FRZ_CAL: exp_rd = m_pfc;
      `ADDR_IRQ_EN:       exp_rd = m_ien;
      `ADDR_EVENT_FLAGS:  exp_rd = m_flg;
      `ADDR_CTRL_STATUS:  exp_rd = m_wr1 * 2 + (m_st >= 2);
      default:            exp_rd = 0;
    endcase
  end
  endfunction

  task apb(input w, input [7:0] a, input [31:0] d);
  begin
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
    `CHK(err, (a > `ADDR_CTRL_STATUS) || (a[1:0] != 2'h0));
  end
  endtask

  task wr(input [7:0] a, input [31:0] d);
  begin
    apb(1'b1, a, d);
    case (a)
      `ADDR_CLK_SRC_PS:
      begin
        if (special_mode_i || !m_wr1) m_clk = d & `CLK_SRC_PS_MASK;
        m_wr1 = 1;
      end
      `ADDR_PROT_FRZ_CAL:
      begin
        m_pfc = d & `PROT_FRZ_CAL_MASK;
        m_st = nxt_st(m_st, d[7:6]);
      end
      `ADDR_IRQ_EN: m_ien = d & `IRQ_EN_MASK;
      `ADDR_EVENT_FLAGS: m_flg = m_flg & ~d;
    endcase
  end
  endtask

  task rc(input [7:0] a);
  begin
    apb(1'b0, a, 32'h0);
    `CHK(rd, exp_rd(a));
  end
  endtask

  task rst(input por, input integer n);
  begin
    arst_n_i <= 1'b0;
    por_arst_n_i <= ~por;
    repeat (n) @(posedge clk_i);
    arst_n_i <= 1'b1;
    por_arst_n_i <= 1'b1;
    @(posedge clk_i);
    m_pfc = 0;
    m_ien = 0;
    m_flg = 0;
    m_st = 0;
    m_wr1 = 0;
    if (por) m_clk = 0;
  end
  endtask

  task irqc;
  begin
    @(negedge clk_i);
    `CHK(irq, m_flg & m_ien);
    @(posedge clk_i);
  end
  endtask

  task pulse(input [5:0] m);
  begin
    set_b <= m;
    @(posedge clk_i);
    set_b <= 6'h00;
    m_flg = m_flg | (m & `IRQ_EN_MASK);
    irqc;
  end
  endtask

  task wt;
  begin
    t = 0;
    while (tick !== 1'b1 && t < 9000)
    begin
      @(posedge clk_i);
      t = t + 1;
    end
  end
  endtask

  // First interval after a source change may be short, so it is skipped
  task meas(input integer e);
  begin
    wt;
    repeat (2)
    begin
      @(posedge clk_i);
      wt;
    end
    `CHK(t + 1, e);
  end
  endtask

  task quiet(input s);
  begin
    p = 0;
    repeat (300)
    begin
      @(posedge clk_i);
      p = p + tick + (s ? src_clk : 1'b0);
    end
  end
  endtask

  task finish_test;
  begin
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  initial
  begin
    rst(1'b1, 20);
    for (i = 0; i < 6; i = i + 1)
      rc(8'h04 * i);
    rc(8'h06);
    wr(`ADDR_CLK_SRC_PS, 32'h85);
    wr(`ADDR_CLK_SRC_PS, 32'h4a);
    rc(`ADDR_CLK_SRC_PS);
    wr(8'h20, 32'hff);
    for (i = 0; i < 12; i = i + 1)
    begin
      wr(`ADDR_PROT_FRZ_CAL, {kseq[23 - 2 * i -: 2], 6'h0} |
         ($random(seed) & 32'h0a));
      rc(`ADDR_PROT_FRZ_CAL);
      rc(`ADDR_CTRL_STATUS);
      `CHK(wp, m_st >= 2);
    end
    // Mid-sequence state stands for an unknown one: lock, then unlock
    for (i = 0; i < 6; i = i + 1)
      wr(`ADDR_PROT_FRZ_CAL, {ulk[11 - 2 * i -: 2], 6'h00});
    `CHK(wp, 1'b0);
    wr(`ADDR_PROT_FRZ_CAL, 32'h80);
    wr(`ADDR_PROT_FRZ_CAL, 32'h80);
    `CHK(wp, 1'b1);
    wr(`ADDR_IRQ_EN, 32'h3d);
    rst(1'b0, 3);
    for (i = 0; i < 5; i = i + 1)
      rc(8'h04 * i);
    `CHK(wp, 1'b0);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(`ADDR_IRQ_EN, $random(seed));
      irqc;
      pulse($random(seed));
      wr(`ADDR_EVENT_FLAGS, $random(seed));
      irqc;
      rc(`ADDR_EVENT_FLAGS);
    end
    special_mode_i <= 1'b1;
    ps = $random(seed) & 3;
    wr(`ADDR_CLK_SRC_PS, ps);
    rc(`ADDR_CLK_SRC_PS);
    meas(320 * (ps + 1));
    wr(`ADDR_CLK_SRC_PS, 32'h40);
    meas(40);
    // Source clock out follows the watch crystal: 20 of every 40 cycles high
    p = 0;
    repeat (400)
    begin
      @(posedge clk_i);
      p = p + src_clk;
    end
    `CHK(p, 200);
    wr(`ADDR_CLK_SRC_PS, 32'h80);
    meas(3200);
    wr(`ADDR_CLK_SRC_PS, 32'hc0);
    quiet(1'b1);
    `CHK(p, 0);
    wr(`ADDR_CLK_SRC_PS, 32'h40);
    freeze <= 1'b1;
    wr(`ADDR_PROT_FRZ_CAL, 32'h08);
    quiet(1'b0);
    `CHK(p, 0);
    wr(`ADDR_PROT_FRZ_CAL, 32'h00);
    meas(40);
    freeze <= 1'b0;
    wr(`ADDR_PROT_FRZ_CAL, 32'h08);
    meas(40);
    wr(`ADDR_CLK_SRC_PS, 32'h40);
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(`ADDR_PROT_FRZ_CAL, (i < 2) ? 32'h02 : 32'h00);
      comp_1hz <= (i != 1);
      repeat (6) @(posedge clk_i);
      `CHK(cal_out, (i == 2) ? src_clk : (i == 0));
    end
    rst(1'b1, 3);
    rc(`ADDR_CLK_SRC_PS);
    finish_test;
  end
endmodule
